//--- rtl/flash_status_poller.sv
// host side poller: runs the toggle-bit completion check on an external flash over apb orders
// Contract
// - host reads full byte twice in a row and compares toggle bits
// - toggle unchanged over two reads means done; next read gives array data
// - still toggling: check limit flag, if high test toggling again
// - still toggling after limit flag high: failed, host writes reset command
// - after stopping to do other work, restart check from first two reads
// - after any limit failure host issues reset command
// - host ignores bit three only if extra commands come under 50 us apart
// - host confirms acceptance, then checks bit three before and after extras
// - polling and bit two reads use program address or erase-selected sector
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module flash_status_poller #(
    parameter int rd_cycles  = flash_status_pkg::read_cycles,
    parameter int wr_cycles  = flash_status_pkg::write_cycles,
    parameter int rec_cycles = flash_status_pkg::recover_cycles
) (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // flash pins
    output flash_status_pkg::flash_pins_s  flash_pins,
    input  wire logic [7:0]                flash_dq_in,
    input  wire logic                      ready_busy_out
);

    ////////////////////////////////////////////////////////////////////////
    // poll state machine
    typedef enum logic [7:0] {
        p_idle    = 8'b0000_0001,
        p_read1   = 8'b0000_0010,
        p_read2   = 8'b0000_0100,
        p_read3   = 8'b0000_1000,
        p_read4   = 8'b0001_0000,
        p_reset   = 8'b0010_0000,
        p_final   = 8'b0100_0000,
        p_report  = 8'b1000_0000
    } poll_e;

    poll_e       state;
    poll_e       next_state;
    logic [18:0] status_addr;
    logic        erase_mode;
    logic [7:0]  first_byte;
    logic [7:0]  last_byte;
    logic [7:0]  array_byte;
    logic        busy;
    logic        done;
    logic        fail;
    logic        timer_seen;
    logic        suspend_seen;

    // engine wires
    logic                        req_valid;
    flash_status_pkg::bus_req_s  req;
    logic                        req_ready;
    logic                        rsp_valid;
    logic [7:0]                  rsp_data;

    // toggle compare: bit six always, bit two in erase mode only
    function automatic logic toggled(input logic [7:0] a, input logic [7:0] b, input logic erase);
        toggled = (a[flash_status_pkg::dq_toggle1] != b[flash_status_pkg::dq_toggle1]) ||
                  (erase && (a[flash_status_pkg::dq_toggle2] != b[flash_status_pkg::dq_toggle2]));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, unmapped reads zero with error
    wire apb_access = psel && penable;
    wire wr_ctrl    = apb_access && pwrite && (paddr == flash_status_pkg::off_ctrl);
    wire wr_addr    = apb_access && pwrite && (paddr == flash_status_pkg::off_addr);
    wire hit        = (paddr == flash_status_pkg::off_ctrl) || (paddr == flash_status_pkg::off_addr) ||
                      (paddr == flash_status_pkg::off_status) || (paddr == flash_status_pkg::off_data);
    wire start_cmd  = wr_ctrl && pwdata[flash_status_pkg::ctrl_start_bit] && !busy;
    wire abort_cmd  = wr_ctrl && pwdata[flash_status_pkg::ctrl_abort_bit];

    assign pready  = 1'b1;
    assign pslverr = apb_access && !hit;

    wire [31:0] status_word = {26'h0000000,
                               suspend_seen,
                               timer_seen,
                               ready_busy_out,
                               fail,
                               done,
                               busy};

    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_access && !pwrite) begin
            unique case (paddr)
                flash_status_pkg::off_ctrl:   prdata = {29'h0000_0000, erase_mode, 2'b00};
                flash_status_pkg::off_addr:   prdata = {13'h0000, status_addr};
                flash_status_pkg::off_status: prdata = status_word;
                flash_status_pkg::off_data:   prdata = {24'h00_0000, array_byte};
                default:                      prdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // engine requests: status reads at the valid address, or the reset command
    // valid status address
    // the cycle that brings an answer issues nothing, so each request is built from its own state
    assign req_valid  = (state != p_idle) && (state != p_report) && req_ready && !rsp_valid;
    assign req.write  = (state == p_reset);
    assign req.addr   = status_addr;
    assign req.data   = flash_status_pkg::cmd_reset;

    wire tog12 = toggled(first_byte, rsp_data, erase_mode);
    wire tog34 = toggled(last_byte, rsp_data, erase_mode);

    // next state on each completed bus cycle
    always_comb begin
        next_state = state;
        unique case (state)
            p_idle: begin
                // every start begins at the two-read step
                if (start_cmd) begin
                    next_state = p_read1;
                end
            end
            p_read1: begin
                if (rsp_valid) begin
                    next_state = p_read2;
                end
            end
            p_read2: begin
                // no toggle: read array data next
                if (rsp_valid) begin
                    if (!tog12) begin
                        next_state = p_final;
                    end else if (rsp_data[flash_status_pkg::dq_limit]) begin
                        next_state = p_read3;
                    end else begin
                        next_state = p_read1;
                    end
                end
            end
            p_read3: begin
                if (rsp_valid) begin
                    next_state = p_read4;
                end
            end
            p_read4: begin
                if (rsp_valid) begin
                    next_state = tog34 ? p_reset : p_final;
                end
            end
            p_reset: begin
                if (rsp_valid) begin
                    next_state = p_report;
                end
            end
            p_final: begin
                if (rsp_valid) begin
                    next_state = p_report;
                end
            end
            p_report: next_state = p_idle;
        endcase
        if (abort_cmd) begin
            next_state = p_idle;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state and configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= p_idle;
            status_addr <= flash_status_pkg::addr_reset;
            erase_mode  <= 1'b0;
        end else begin
            state <= next_state;
            if (wr_addr && !busy) begin
                status_addr <= pwdata[18:0];
            end
            if (start_cmd) begin
                erase_mode <= pwdata[flash_status_pkg::ctrl_erase_bit];
            end
        end
    end

    // captured reads: first of a pair, and the first read of the recheck pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_byte <= 8'h00;
            last_byte  <= 8'h00;
            array_byte <= 8'h00;
        end else if (rsp_valid) begin
            if (state == p_read1) begin
                first_byte <= rsp_data;
            end
            if (state == p_read3) begin
                last_byte <= rsp_data;
            end
            if (state == p_final) begin
                array_byte <= rsp_data;
            end
        end
    end

    // outcome flags; a new start clears them and sets busy
    // bit three seen high means erase window closed
    // host can read the timer bit after each extra command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy         <= 1'b0;
            done         <= 1'b0;
            fail         <= 1'b0;
            timer_seen   <= 1'b0;
            suspend_seen <= 1'b0;
        end else begin
            if (start_cmd) begin
                busy         <= 1'b1;
                done         <= 1'b0;
                fail         <= 1'b0;
                timer_seen   <= 1'b0;
                suspend_seen <= 1'b0;
            end else if (abort_cmd || state == p_report) begin
                busy <= 1'b0;
            end
            if (state == p_report) begin
                done <= 1'b1;
            end
            if (state == p_reset && rsp_valid) begin
                fail <= 1'b1;
            end
            if (rsp_valid && (state == p_read1 || state == p_read2)) begin
                timer_seen   <= rsp_data[flash_status_pkg::dq_timer];
            end
            // bit six steady while bit two toggles: suspended sector
            if (rsp_valid && state == p_read2) begin
                suspend_seen <= erase_mode &&
                                !(first_byte[flash_status_pkg::dq_toggle1] ^ rsp_data[flash_status_pkg::dq_toggle1]) &&
                                (first_byte[flash_status_pkg::dq_toggle2] ^ rsp_data[flash_status_pkg::dq_toggle2]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strobe engine
    flash_bus_cycle #(
        .rd_cycles  (rd_cycles),
        .wr_cycles  (wr_cycles),
        .rec_cycles (rec_cycles)
    ) u_cycle (
        .pclk      (pclk),
        .presetn   (presetn),
        .req_valid (req_valid),
        .req       (req),
        .req_ready (req_ready),
        .rsp_valid (rsp_valid),
        .rsp_data  (rsp_data),
        .pins      (flash_pins),
        .dq_in     (flash_dq_in)
    );

endmodule
`default_nettype wire

//--- rtl/flash_status_pkg.sv
// package: register map, field layout and timing for the flash status poller
package flash_status_pkg;

    // apb register byte offsets
    localparam logic [7:0] off_ctrl    = 8'h00;
    localparam logic [7:0] off_addr    = 8'h04;
    localparam logic [7:0] off_status  = 8'h08;
    localparam logic [7:0] off_data    = 8'h0c;

    // ctrl fields
    localparam int ctrl_start_bit   = 0;
    localparam int ctrl_abort_bit   = 1;
    localparam int ctrl_erase_bit   = 2;

    // status fields
    localparam int st_busy_bit      = 0;
    localparam int st_done_bit      = 1;
    localparam int st_fail_bit      = 2;
    localparam int st_rb_bit        = 3;
    localparam int st_timer_bit     = 4;
    localparam int st_suspend_bit   = 5;

    // flash data bit positions
    localparam int dq_poll          = 7;
    localparam int dq_toggle1       = 6;
    localparam int dq_limit         = 5;
    localparam int dq_timer         = 3;
    localparam int dq_toggle2       = 2;

    // reset values
    localparam logic [18:0] addr_reset = 19'h00000;

    // bus timing: strobe low time and recovery, in ns
    localparam int clk_period_ns    = 40;
    localparam int read_access_ns   = 70;
    localparam int write_pulse_ns   = 35;
    localparam int reset_cmd_ns     = 40;
    localparam int read_cycles      = (read_access_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int write_cycles     = (write_pulse_ns + clk_period_ns - 1) / clk_period_ns;
    localparam int recover_cycles   = (reset_cmd_ns + clk_period_ns - 1) / clk_period_ns;

    // reset command byte
    localparam logic [7:0] cmd_reset = 8'hf0;

    // flash pin bundle driven by the controller
    typedef struct packed {
        logic [18:0] addr;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [7:0]  dq_out;
        logic        dq_oe_n;
    } flash_pins_s;

    // bus cycle request to the strobe engine
    typedef struct packed {
        logic        write;
        logic [18:0] addr;
        logic [7:0]  data;
    } bus_req_s;

endpackage

//--- rtl/flash_bus_cycle.sv
// strobe engine: one read or write cycle on the flash pins per request
`timescale 1ns/1ns
`default_nettype none
module flash_bus_cycle #(
    parameter int rd_cycles  = flash_status_pkg::read_cycles,
    parameter int wr_cycles  = flash_status_pkg::write_cycles,
    parameter int rec_cycles = flash_status_pkg::recover_cycles
) (
    // clock and reset
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // request and answer
    input  wire logic                        req_valid,
    input  wire flash_status_pkg::bus_req_s  req,
    output logic                             req_ready,
    output logic                             rsp_valid,
    output logic [7:0]                       rsp_data,
    // flash pins
    output flash_status_pkg::flash_pins_s    pins,
    input  wire logic [7:0]                  dq_in
);

    typedef enum logic [2:0] {
        s_idle   = 3'b001,
        s_strobe = 3'b010,
        s_rec    = 3'b100
    } cyc_e;

    cyc_e       state;
    logic [3:0] cnt;
    logic       is_write;

    wire strobe_end = (cnt == 4'h0);

    assign req_ready = (state == s_idle);

    ////////////////////////////////////////////////////////////////////////
    // sequence: address setup with strobe, then recovery high time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= s_idle;
            cnt       <= 4'h0;
            is_write  <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= 8'h00;
            pins      <= '{addr: 19'h00000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                           dq_out: 8'h00, dq_oe_n: 1'b1};
        end else begin
            rsp_valid <= 1'b0;
            unique case (state)
                s_idle: begin
                    if (req_valid) begin
                        state        <= s_strobe;
                        is_write     <= req.write;
                        pins.addr    <= req.addr;
                        pins.dq_out  <= req.data;
                        pins.ce_n    <= 1'b0;
                        pins.oe_n    <= req.write;
                        pins.we_n    <= ~req.write;
                        pins.dq_oe_n <= ~req.write;
                        cnt          <= req.write ? 4'(wr_cycles - 1) : 4'(rd_cycles - 1);
                    end
                end
                s_strobe: begin
                    if (strobe_end) begin
                        // data latched at the rising strobe; each ce or oe frame is one read
                        state        <= s_rec;
                        pins.ce_n    <= 1'b1;
                        pins.oe_n    <= 1'b1;
                        pins.we_n    <= 1'b1;
                        rsp_data     <= is_write ? 8'h00 : dq_in;
                        cnt          <= 4'(rec_cycles - 1);
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                s_rec: begin
                    // keep data driven one extra cycle for hold time
                    pins.dq_oe_n <= 1'b1;
                    if (strobe_end) begin
                        state     <= s_idle;
                        rsp_valid <= 1'b1;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: state <= s_idle;
            endcase
        end
    end

endmodule
`default_nettype wire

//--- test/flash_model.sv
// behavioural flash device answering the poller's status reads
`timescale 1ns/1ns
`default_nettype none
module flash_model (
    // controller pins
    input  wire flash_status_pkg::flash_pins_s pins,
    // scenario controls
    input  wire logic                          op_go,
    input  wire logic [3:0]                    toggle_reads,
    input  wire logic [3:0]                    limit_after,
    input  wire logic                          stop_at_limit,
    input  wire logic                          erase_op,
    input  wire logic                          suspend,
    input  wire logic                          timer_done,
    input  wire logic [7:0]                    array_byte,
    // device outputs
    output logic [7:0]                         dq,
    output logic                               ready_busy_out,
    output int                                 resets_seen
);
    logic       active = 1'b0, t6 = 1'b0, t2 = 1'b0, lim = 1'b0;
    logic [3:0] reads = 4'h0;
    logic [7:0] last = 8'h00;
    wire        rd = !pins.ce_n && !pins.oe_n;
    wire        wr = !pins.ce_n && !pins.we_n && !pins.dq_oe_n;
    wire        in_sector = erase_op && pins.addr[18:13] == 6'h3f;
    wire [7:0]  status = {erase_op ? suspend : ~array_byte[7], t6, lim, 1'b0, timer_done, t2, array_byte[1:0]};
    // status while running; released bus shows inverse, never a held value
    assign dq = rd ? (active ? status : array_byte) : ~last;
    // busy only while really programming or erasing
    assign ready_busy_out = !(active && !suspend);
    initial resets_seen = 0;
    // remember the last driven byte
    always @(dq) if (rd) last = dq;
    always @(posedge op_go) begin
        active = 1'b1;
        reads = 4'h0;
        lim = 1'b0;
    end
    // status advances at the end of each read
    always @(negedge rd) begin
        if (active && !suspend) begin
            reads = reads + 4'h1;
            t6 = ~t6;
        end
        if (active && in_sector) t2 = ~t2;
        // a device that stops just as the flag rises still shows the flag once
        if (lim && stop_at_limit) active = 1'b0;
        if (active && reads >= limit_after) lim = 1'b1;
        if (reads >= toggle_reads && !lim) active = 1'b0;
    end
    // only the reset command acts; no erase command is ever written
    always @(posedge wr) begin
        if (pins.dq_out == flash_status_pkg::cmd_reset) begin
            active = 1'b0;
            lim = 1'b0;
            resets_seen++;
        end
    end
endmodule
`default_nettype wire

//--- test/flash_status_poller_checker.sv
// concurrent checks on the poller's apb slave and flash strobes
`timescale 1ns/1ns
`default_nettype none
module flash_status_poller_checker #(
    parameter int rd_cycles  = 2,
    parameter int wr_cycles  = 1,
    parameter int rec_cycles = 1
) (
    // clock and reset
    input wire logic                          pclk,
    input wire logic                          presetn,
    // apb
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [7:0]                    paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [31:0]                   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    // flash side
    input wire flash_status_pkg::flash_pins_s flash_pins,
    input wire logic [7:0]                    flash_dq_in,
    input wire logic                          ready_busy_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // strobe decode
    wire rd_on = !flash_pins.ce_n && !flash_pins.oe_n;
    wire wr_on = !flash_pins.ce_n && !flash_pins.we_n;
    wire acc = psel && penable;
    // a read opens, then must hold for the access time before closing
    sequence rd_open;
        $rose(rd_on);
    endsequence
    sequence rd_hold;
        rd_on [*2];
    endsequence
    ////////////////////////////////////////////////////////////////
    read_len_a: assert property (rd_open |-> rd_hold ##[1:2] !rd_on)
        else $error("read strobe length wrong");
    read_quiet_a: assert property (rd_on |-> flash_pins.dq_oe_n && flash_pins.we_n)
        else $error("bus driven during read");
    reset_cmd_a: assert property (wr_on |-> !flash_pins.dq_oe_n && flash_pins.oe_n &&
        flash_pins.dq_out == flash_status_pkg::cmd_reset)
        else $error("write is not the reset command");
    wr_pulse_a: assert property ($rose(wr_on) |=> !wr_on)
        else $error("write pulse too long");
    addr_hold_a: assert property (rd_on && $past(rd_on) |-> $stable(flash_pins.addr))
        else $error("address moved in a read");
    rb_mirror_a: assert property (acc && !pwrite && paddr == flash_status_pkg::off_status |->
        prdata[flash_status_pkg::st_rb_bit] == ready_busy_out)
        else $error("ready busy not shown");
    zero_wait_a: assert property (acc |-> pready)
        else $error("wait state inserted");
    bad_addr_a: assert property (acc && (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0) |-> pslverr)
        else $error("unmapped access not refused");
    start_read_a: assert property (acc && pwrite && paddr == flash_status_pkg::off_ctrl &&
        pwdata[1:0] == 2'b01 |-> ##[1:8] rd_on)
        else $error("start gave no read");
endmodule
bind flash_status_poller flash_status_poller_checker #(
    .rd_cycles(rd_cycles), .wr_cycles(wr_cycles), .rec_cycles(rec_cycles)
) i_flash_status_poller_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_pins(flash_pins), .flash_dq_in(flash_dq_in), .ready_busy_out(ready_busy_out)
);
`default_nettype wire

//--- test/flash_status_poller_tb.sv
// self-checking bench for the flash status poller
`timescale 1ns/1ns
`default_nettype none
module flash_status_poller_tb;
    typedef struct packed {
        logic [31:0] exp;
        logic [31:0] mask;
        logic        err;
    } note_s;
    logic                          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]                    paddr = 8'h00, array_byte = 8'h00, dq;
    logic [31:0]                   pwdata = 32'h0, prdata, q;
    logic                          pready, pslverr, rb, op_go = 1'b0, stop_at_limit = 1'b0;
    logic                          erase_op = 1'b0, suspend = 1'b0, timer_done = 1'b0;
    logic [3:0]                    toggle_reads = 4'h0, limit_after = 4'hf;
    logic [18:0]                   addr;
    flash_status_pkg::flash_pins_s pins;
    int                            resets, fails = 0, err_count = 0, num_checks = 0, seed = 32'h846c;
    note_s                         notes[$];
    always #20 pclk = ~pclk;
    flash_status_poller i_flash_status_poller (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_pins(pins), .flash_dq_in(dq), .ready_busy_out(rb));
    flash_model i_flash_model (
        .pins(pins), .op_go(op_go), .toggle_reads(toggle_reads), .limit_after(limit_after),
        .stop_at_limit(stop_at_limit), .erase_op(erase_op), .suspend(suspend), .timer_done(timer_done),
        .array_byte(array_byte), .dq(dq), .ready_busy_out(rb), .resets_seen(resets));
    ////////////////////////////////////////////////////////////////
    // compare tasks, one per kind of result
    task automatic check32(input logic [31:0] got, input note_s n);
        num_checks++;
        if (((got ^ n.exp) & n.mask) !== 32'h0) begin
            err_count++;
            $display("Error %0t: data %h expected %h", $time, got, n.exp);
        end
    endtask
    task automatic check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    // one apb transfer; the expectation is queued for the monitor
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                       input logic e, output logic [31:0] r);
        notes.push_back('{d, w ? 32'h0 : m, e});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // monitor: oldest note against each completed transfer
    note_s cur;
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            cur = notes.pop_front();
            check32(prdata, cur);
            check_bit(pslverr, cur.err);
        end
    end
    task automatic wait_idle();
        q = 32'h1;
        while (q[flash_status_pkg::st_busy_bit] !== 1'b0) apb(0, flash_status_pkg::off_status, 0, 0, 0, q);
    endtask
    // one poll run against a device set up for the given behaviour
    task automatic run_case(input logic [3:0] tr, input logic [3:0] la, input logic sl, input logic ef,
                            input logic er);
        @(posedge pclk);
        array_byte <= 8'($random(seed));
        addr = {6'h3f, 13'($random(seed))};
        toggle_reads <= tr;
        limit_after <= la;
        stop_at_limit <= sl;
        suspend <= 1'b0;
        op_go <= tr != 4'h0;
        @(posedge pclk);
        op_go <= 1'b0;
        fails = fails + ef;
        apb(1, flash_status_pkg::off_addr, {13'h0, addr}, 0, 0, q);
        apb(1, flash_status_pkg::off_ctrl, {29'h0, er, 2'b01}, 0, 0, q);
        wait_idle();
        apb(0, flash_status_pkg::off_status, {28'h0, 1'b1, ef, 2'b10}, 32'hf, 0, q);
        apb(0, flash_status_pkg::off_data, {24'h0, array_byte}, ef ? 32'h0 : 32'hff, 0, q);
        check32(resets, '{fails, 32'hffffffff, 1'b0});
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        $display("Error %0t: timeout", $time);
        summarize();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, flash_status_pkg::off_status, 0, 32'h7, 0, q);
        apb(0, flash_status_pkg::off_addr, 0, 32'h7ffff, 0, q);
        apb(1, 8'h10, 32'h1, 0, 1, q);
        apb(0, 8'h14, 0, 0, 1, q);
        run_case(4'h0, 4'hf, 0, 0, 0);
        run_case(4'h4, 4'hf, 0, 0, 0);
        run_case(4'hf, 4'h3, 0, 1, 0);
        run_case(4'hf, 4'h3, 1, 0, 0);
        // suspended erase never settles, so the poll is aborted and restarted on resume
        @(posedge pclk);
        erase_op <= 1'b1;
        suspend <= 1'b1;
        timer_done <= 1'b1;
        op_go <= 1'b1;
        @(posedge pclk);
        op_go <= 1'b0;
        apb(1, flash_status_pkg::off_addr, {13'h0, 19'h7e000}, 0, 0, q);
        apb(1, flash_status_pkg::off_ctrl, 32'h5, 0, 0, q);
        repeat (60) @(posedge pclk);
        apb(0, flash_status_pkg::off_status, 32'h39, 32'h3f, 0, q);
        apb(1, flash_status_pkg::off_ctrl, 32'h2, 0, 0, q);
        wait_idle();
        run_case(4'h6, 4'hf, 0, 0, 1);
        summarize();
    end
endmodule
`default_nettype wire
